// ===== include/dmc_pkg.sv
/*
 * Shared constants and types of the DMA engine control pair: register
 * map of the engine, field positions, mode codes, host order registers.
 * Assumes a single 25 MHz clock domain for both ends.
 */
package dmc_pkg;
	localparam int NCH = 2;
	localparam int CW  = 1;

	// engine register map, word index on the register port
	localparam logic [5:0] A_GCTL      = 6'h00;
	localparam logic [5:0] A_UPPER     = 6'h01;
	localparam logic [5:0] A_LOWER     = 6'h02;
	localparam logic [5:0] A_BUF       = 6'h03;
	localparam logic [5:0] A_CH0       = 6'h08;
	localparam logic [5:0] A_CH_STRIDE = 6'h08;
	localparam logic [2:0] O_CTL       = 3'h0;
	localparam logic [2:0] O_INT       = 3'h1;
	localparam logic [2:0] O_SRC       = 3'h2;
	localparam logic [2:0] O_DST       = 3'h3;
	localparam logic [2:0] O_CNT       = 3'h4;

	// engine_global_control fields
	localparam int B_ON = 15;
	localparam int B_RR = 0;
	// channel_control fields
	localparam int B_DUMMY_WRITE_MODE  = 10;
	localparam int B_RELOAD = 9;
	localparam int B_REQ    = 8;
	localparam int B_SA     = 6;
	localparam int B_DA     = 4;
	localparam int B_TR     = 2;
	localparam int B_SIZE   = 1;
	localparam int B_EN     = 0;
	// channel_interrupt_reg fields
	localparam int I_CHSEL = 8;
	localparam int I_HIGH  = 7;
	localparam int I_LOW   = 6;
	localparam int I_DONE  = 5;
	localparam int I_OVR   = 3;

	localparam logic [15:0] CTL_MASK = 16'h07FF;
	localparam logic [15:0] INT_MASK = 16'h7FF9;
	localparam logic [15:0] RST16    = 16'h0000;
	localparam logic [15:0] SFR_TOP  = 16'h0FFF;

	localparam logic [1:0] AM_FIX = 2'h0;
	localparam logic [1:0] AM_INC = 2'h1;
	localparam logic [1:0] AM_DEC = 2'h2;
	localparam logic [1:0] AM_PIA = 2'h3;

	// host order registers
	localparam logic [2:0] U_SRC = 3'h0;
	localparam logic [2:0] U_DST = 3'h1;
	localparam logic [2:0] U_CNT = 3'h2;
	localparam logic [2:0] U_CTL = 3'h3;
	localparam logic [2:0] U_UP  = 3'h4;
	localparam logic [2:0] U_LOW = 3'h5;
	localparam logic [2:0] U_CMD = 3'h6;
	localparam int C_GO   = 0;
	localparam int C_RR   = 1;
	localparam int C_CH   = 4;
	localparam int C_BUSY = 15;
	localparam logic [3:0] STEP_LAST = 4'hA;

	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_RD   = 5'h02,
		S_CAP  = 5'h04,
		S_WR   = 5'h08,
		S_NW   = 5'h10
	} dmc_st_t;
endpackage

// ===== include/dmc_if.sv
/*
 * Register port between the host sequencer and the DMA engine,
 * plus the per-channel interrupt lines back to the host.
 * Assumes both ends run on the clock given to the interface.
 */
`timescale 1ns/10ps
interface dmc_if
	import dmc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n
);
	logic [5:0]     reg_addr;
	logic [15:0]    reg_wdata;
	logic           reg_wr;
	logic           reg_rd;
	logic [15:0]    reg_rdata;
	logic [NCH-1:0] irq;

	modport dev (input reg_addr, reg_wdata, reg_wr, reg_rd,
		output reg_rdata, irq);
	modport host (output reg_addr, reg_wdata, reg_wr, reg_rd,
		input reg_rdata, irq);
endinterface

// ===== verilog/dmc_device.sv
/*
 * DMA engine end: registers, channel arbitration and the data space
 * master that moves one item per transaction.
 * Assumes a data space answering reads one cycle after the strobe
 * and peripheral triggers as one-cycle pulses.
 */
// Our own choices: the address map and the plain strobed port.
// Summary of operation
// - engine_on clear aborts all channel activity
// - bit 0 selects round robin or fixed
// - null write repeats each write to source
// - reload restores pointers and count next start
// - repeated modes always restore transaction count
// - software request starts, cleared at completion
// - transfers per software request follow mode
// - source field: fixed, increment, decrement, indirect
// - destination field: same four addressing choices
// - transfer mode field selects four modes
// - size bit: byte when set, word default
// - channel_on bit enables the channel
// - software enables engine, limits, disables channel
// - software loads count per mode meaning
// - indirect mode pointer holds base address
// - channel enabled last, then trigger source
// - only original count kept for pointer recovery
// - each channel power gated on its own
// - reserved bit kept zero, unimplemented read zero
// - four engine registers, five per channel
// - limit violation ends transaction, raises interrupt
// - address lsb picks byte lane
// - fixed priority lowest wins, no immediate retrigger; code re-serves the just-served channel at once if no other is pending
`timescale 1ns/10ps
module dmc_device
	import dmc_pkg::*;
(
	// clock and reset
	input  wire logic           clk,
	input  wire logic           rst_n,
	// register port
	dmc_if.dev                  bus,
	// data space master
	output logic [15:0]         mem_addr,
	output logic [15:0]         mem_wdata,
	output logic [1:0]          mem_be,
	output logic                mem_rd,
	output logic                mem_wr,
	input  wire logic [15:0]    mem_rdata,
	// peripheral side
	input  wire logic [NCH-1:0] trig,
	input  wire logic [NCH-1:0] module_power_gate
);
	typedef struct packed {
		logic                      on;
		logic                      rr;
		logic [15:0]               upper;
		logic [15:0]               lower;
		logic [15:0]               dbuf;
		logic [NCH-1:0][15:0]      ctl;
		logic [NCH-1:0][15:0]      intr;
		logic [NCH-1:0][15:0]      src;
		logic [NCH-1:0][15:0]      dst;
		logic [NCH-1:0][15:0]      cnt;
		logic [NCH-1:0][15:0]      orig;
		logic [NCH-1:0]            pend;
		logic [NCH-1:0]            rearm;
		dmc_st_t                   st;
		logic [CW-1:0]             ch;
		logic [CW-1:0]             last;
		logic                      just;
		logic [15:0]               rdata;
		logic [15:0]               maddr;
		logic [15:0]               mwdata;
		logic [1:0]                mbe;
		logic                      mrd;
		logic                      mwr;
	} dmc_dev_s_t;

	localparam dmc_dev_s_t RST_S = '{st: S_IDLE, default: '0};

	dmc_dev_s_t s_r;
	dmc_dev_s_t s_nxt;

	function automatic logic [15:0] adv(input logic [15:0] p,
		input logic [1:0] am, input logic by);
		logic [15:0] stp;
		stp = by ? 16'h0001 : 16'h0002;
		case (am)
		AM_INC: adv = p + stp;
		AM_DEC: adv = p - stp;
		default: adv = p;
		endcase
	endfunction

	// pointer rebuilt from items already moved
	function automatic logic [15:0] rec(input logic [15:0] p,
		input logic [1:0] am, input logic [15:0] used, input logic by);
		logic [15:0] off;
		off = by ? used : {used[14:0], 1'b0};
		case (am)
		AM_INC: rec = p - off;
		AM_DEC: rec = p + off;
		default: rec = p;
		endcase
	endfunction

	function automatic logic [1:0] lane(input logic [15:0] a,
		input logic by);
		lane = !by ? 2'h3 : (a[0] ? 2'h2 : 2'h1);
	endfunction

	logic [CW-1:0] c;
	logic [CW-1:0] j;
	logic [CW-1:0] pk;
	logic          found;
	logic          fin;
	logic          abt;
	logic [15:0]   a;
	logic [15:0]   cl;
	logic [15:0]   used;
	logic          by;
	logic          chhit;

	always_comb begin
		s_nxt = s_r;
		c = s_r.ch;
		j = '0;
		pk = s_r.last;
		found = 1'b0;
		fin = 1'b0;
		abt = 1'b0;
		a = RST16;
		used = RST16;
		chhit = 1'b0;
		s_nxt.mrd = 1'b0;
		s_nxt.mwr = 1'b0;
		s_nxt.just = 1'b0;

		// software writes first so that hardware sets win below
		if (bus.reg_wr) begin
			case (bus.reg_addr)
			A_GCTL: begin
				s_nxt.on = bus.reg_wdata[B_ON];
				s_nxt.rr = bus.reg_wdata[B_RR];
			end
			A_UPPER: s_nxt.upper = bus.reg_wdata;
			A_LOWER: s_nxt.lower = bus.reg_wdata;
			A_BUF: s_nxt.dbuf = bus.reg_wdata;
			default: ;
			endcase
			for (int i = 0; i < NCH; i++) begin
				if ({bus.reg_addr[5:3], 3'h0} ==
					6'(int'(A_CH0) + i * int'(A_CH_STRIDE))) begin
					case (bus.reg_addr[2:0])
					O_CTL: if (!module_power_gate[i])
						s_nxt.ctl[i] = bus.reg_wdata & CTL_MASK;
					O_INT: s_nxt.intr[i] = bus.reg_wdata & INT_MASK;
					O_SRC: s_nxt.src[i] = bus.reg_wdata;
					O_DST: s_nxt.dst[i] = bus.reg_wdata;
					O_CNT: begin
						s_nxt.cnt[i] = bus.reg_wdata;
						s_nxt.orig[i] = bus.reg_wdata;
						s_nxt.rearm[i] = 1'b0;
					end
					default: ;
					endcase
				end
			end
		end

		if (bus.reg_rd) begin
			case (bus.reg_addr)
			A_GCTL: s_nxt.rdata = {s_r.on, 14'h0000, s_r.rr};
			A_UPPER: s_nxt.rdata = s_r.upper;
			A_LOWER: s_nxt.rdata = s_r.lower;
			A_BUF: s_nxt.rdata = s_r.dbuf;
			default: s_nxt.rdata = RST16;
			endcase
			for (int i = 0; i < NCH; i++) begin
				if ({bus.reg_addr[5:3], 3'h0} ==
					6'(int'(A_CH0) + i * int'(A_CH_STRIDE))) begin
					case (bus.reg_addr[2:0])
					O_CTL: s_nxt.rdata = s_r.ctl[i] & CTL_MASK;
					O_INT: s_nxt.rdata = s_r.intr[i];
					O_SRC: s_nxt.rdata = s_r.src[i];
					O_DST: s_nxt.rdata = s_r.dst[i];
					O_CNT: s_nxt.rdata = s_r.cnt[i];
					default: s_nxt.rdata = RST16;
					endcase
				end
			end
		end

		// round robin resumes after last served channel
		if (s_r.rr) begin
			for (int k = NCH; k >= 1; k--) begin
				j = CW'((int'(s_r.last) + k) % NCH);
				if (s_r.pend[j]) begin
					found = 1'b1;
					pk = j;
				end
			end
		end else begin
			// lowest wins, only a just-served one yields
			for (int k = NCH - 1; k >= 0; k--) begin
				if (s_r.pend[k] &&
					!(s_r.just && CW'(k) == s_r.last)) begin
					found = 1'b1;
					pk = CW'(k);
				end
			end
			if (!found && s_r.pend[s_r.last]) begin
				found = 1'b1;
			end
		end

		cl = s_r.ctl[c];
		by = cl[B_SIZE];
		case (s_r.st)
		S_IDLE: if (found) begin
			c = pk;
			cl = s_r.ctl[c];
			by = cl[B_SIZE];
			s_nxt.ch = pk;
			if (s_r.rearm[c]) begin
				s_nxt.rearm[c] = 1'b0;
				used = s_r.orig[c] - s_r.cnt[c];
				// restore at start of next operation
				if (cl[B_RELOAD]) begin
					s_nxt.src[c] = rec(s_r.src[c], cl[B_SA+:2], used, by);
					s_nxt.dst[c] = rec(s_r.dst[c], cl[B_DA+:2], used, by);
				end
				if (cl[B_RELOAD] || cl[B_TR]) begin
					s_nxt.cnt[c] = s_r.orig[c];
				end
			end
			a = s_nxt.src[c];
			abt = a > SFR_TOP && (a > s_r.upper || a < s_r.lower);
			if (!abt) begin
				s_nxt.mrd = 1'b1;
				s_nxt.maddr = a;
				s_nxt.mbe = lane(a, by);
				s_nxt.st = S_RD;
			end
		end
		S_RD: s_nxt.st = S_CAP;
		S_CAP: begin
			s_nxt.dbuf = !by ? mem_rdata : {8'h00,
				s_r.maddr[0] ? mem_rdata[15:8] : mem_rdata[7:0]};
			a = s_r.dst[c];
			abt = a > SFR_TOP && (a > s_r.upper || a < s_r.lower);
			if (!abt) begin
				s_nxt.mwr = 1'b1;
				s_nxt.maddr = a;
				s_nxt.mbe = lane(a, by);
				s_nxt.mwdata = by ? {2{s_nxt.dbuf[7:0]}} : s_nxt.dbuf;
				s_nxt.st = S_WR;
			end
		end
		// dummy write of the buffer back to source
		S_WR: if (cl[B_DUMMY_WRITE_MODE]) begin
			s_nxt.mwr = 1'b1;
			s_nxt.maddr = s_r.src[c];
			s_nxt.mbe = lane(s_r.src[c], by);
			s_nxt.st = S_NW;
		end else begin
			fin = 1'b1;
		end
		S_NW: fin = 1'b1;
		default: s_nxt.st = S_IDLE;
		endcase

		// out of limits: end transaction and flag
		if (abt) begin
			s_nxt.intr[c][I_HIGH] = a > s_r.upper;
			s_nxt.intr[c][I_LOW] = a <= s_r.upper;
			s_nxt.ctl[c][B_EN] = 1'b0;
			s_nxt.ctl[c][B_REQ] = 1'b0;
			s_nxt.pend[c] = 1'b0;
			s_nxt.rearm[c] = 1'b1;
			s_nxt.last = c;
			s_nxt.just = 1'b1;
			s_nxt.st = S_IDLE;
		end

		if (fin) begin
			s_nxt.src[c] = adv(s_r.src[c], cl[B_SA+:2], by);
			s_nxt.dst[c] = adv(s_r.dst[c], cl[B_DA+:2], by);
			s_nxt.cnt[c] = s_r.cnt[c] - 16'h0001;
			s_nxt.last = c;
			s_nxt.just = 1'b1;
			s_nxt.st = S_IDLE;
			// one-shot modes disable the channel when count empties
			if (s_nxt.cnt[c] == RST16) begin
				s_nxt.intr[c][I_DONE] = 1'b1;
				s_nxt.rearm[c] = 1'b1;
				if (!cl[B_TR]) begin
					s_nxt.ctl[c][B_EN] = 1'b0;
				end
			end
			// continuous modes run until count empties
			if (s_nxt.cnt[c] == RST16 || !cl[B_TR+1]) begin
				s_nxt.pend[c] = 1'b0;
				s_nxt.ctl[c][B_REQ] = 1'b0;
			end
		end

		// triggers after completion so a request in the finishing cycle is kept
		for (int i = 0; i < NCH; i++) begin
			chhit = s_r.st != S_IDLE && s_r.ch == CW'(i);
			// gated channel stays cleared and idle
			if (module_power_gate[i]) begin
				s_nxt.ctl[i] = RST16;
				s_nxt.pend[i] = 1'b0;
			end else if (!s_nxt.ctl[i][B_EN]) begin
				s_nxt.pend[i] = 1'b0;
			end else if (trig[i] || s_nxt.ctl[i][B_REQ]) begin
				if (trig[i] && (s_r.pend[i] || chhit)) begin
					s_nxt.intr[i][I_OVR] = 1'b1;
				end
				s_nxt.pend[i] = 1'b1;
			end
		end

		if (!s_nxt.on) begin
			s_nxt.st = S_IDLE;
			s_nxt.pend = '0;
			s_nxt.mrd = 1'b0;
			s_nxt.mwr = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= RST_S;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign mem_addr = s_r.maddr;
	assign mem_wdata = s_r.mwdata;
	assign mem_be = s_r.mbe;
	assign mem_rd = s_r.mrd;
	assign mem_wr = s_r.mwr;
	assign bus.reg_rdata = s_r.rdata;

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_irq
			assign bus.irq[g] = s_r.intr[g][I_HIGH] | s_r.intr[g][I_LOW]
				| s_r.intr[g][I_DONE] | s_r.intr[g][I_OVR];
		end
	endgenerate
endmodule

// ===== verilog/dmc_host.sv
/*
 * Host end: takes a channel setup from software registers and plays
 * the setup sequence onto the engine register port, one write a cycle.
 * Assumes software waits for busy to clear before a new go.
 */
`timescale 1ns/10ps
module dmc_host
	import dmc_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// software order port
	input  wire logic [2:0]  usr_addr,
	input  wire logic [15:0] usr_wdata,
	input  wire logic        usr_wr,
	input  wire logic        usr_rd,
	output logic [15:0]      usr_rdata,
	// engine side
	dmc_if.host              bus
);
	typedef struct packed {
		logic [15:0] src;
		logic [15:0] dst;
		logic [15:0] cnt;
		logic [15:0] ctl;
		logic [15:0] up;
		logic [15:0] low;
		logic [15:0] cmd;
		logic [3:0]  step;
		logic [15:0] rdata;
		logic [5:0]  addr;
		logic [15:0] wdata;
		logic        wr;
	} dmc_host_s_t;

	dmc_host_s_t s_r;
	dmc_host_s_t s_nxt;
	logic [5:0]  cb;

	always_comb begin
		s_nxt = s_r;
		s_nxt.wr = 1'b0;
		cb = 6'(A_CH0 + (s_r.cmd[C_CH] ? A_CH_STRIDE : 6'h00));
		if (usr_wr && s_r.step == 4'h0) begin
			case (usr_addr)
			U_SRC: s_nxt.src = usr_wdata;
			U_DST: s_nxt.dst = usr_wdata;
			U_CNT: s_nxt.cnt = usr_wdata;
			U_CTL: s_nxt.ctl = usr_wdata & CTL_MASK;
			U_UP: s_nxt.up = usr_wdata;
			U_LOW: s_nxt.low = usr_wdata;
			U_CMD: begin
				s_nxt.cmd = usr_wdata;
				s_nxt.step = usr_wdata[C_GO] ? 4'h1 : 4'h0;
			end
			default: ;
			endcase
		end
		if (usr_rd) begin
			case (usr_addr)
			U_CMD: s_nxt.rdata = {s_r.step != 4'h0, 13'h0000, bus.irq};
			default: s_nxt.rdata = RST16;
			endcase
		end
		if (s_r.step != 4'h0) begin
			s_nxt.wr = 1'b1;
			s_nxt.step = s_r.step == STEP_LAST ? 4'h0 : s_r.step + 4'h1;
			case (s_r.step)
			4'h1: begin
				s_nxt.addr = A_GCTL;
				s_nxt.wdata = {1'b1, 14'h0000, s_r.cmd[C_RR]};
			end
			4'h2: begin
				s_nxt.addr = A_UPPER;
				s_nxt.wdata = s_r.up;
			end
			4'h3: begin
				s_nxt.addr = A_LOWER;
				s_nxt.wdata = s_r.low;
			end
			4'h4: begin
				s_nxt.addr = cb + 6'(O_CTL);
				s_nxt.wdata = RST16;
			end
			// pointer taken as given, base for indirect
			4'h5: begin
				s_nxt.addr = cb + 6'(O_SRC);
				s_nxt.wdata = s_r.src;
			end
			4'h6: begin
				s_nxt.addr = cb + 6'(O_DST);
				s_nxt.wdata = s_r.dst;
			end
			4'h7: begin
				s_nxt.addr = cb + 6'(O_CNT);
				s_nxt.wdata = s_r.cnt;
			end
			// configure first, enable in next write
			4'h8: begin
				s_nxt.addr = cb + 6'(O_CTL);
				s_nxt.wdata = s_r.ctl & ~16'h0001;
			end
			4'h9: begin
				s_nxt.addr = cb + 6'(O_CTL);
				s_nxt.wdata = s_r.ctl | 16'h0001;
			end
			default: begin
				s_nxt.addr = cb + 6'(O_INT);
				s_nxt.wdata = {1'b0, s_r.cmd[14:8], 8'h00};
			end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign usr_rdata = s_r.rdata;
	assign bus.reg_addr = s_r.addr;
	assign bus.reg_wdata = s_r.wdata;
	assign bus.reg_wr = s_r.wr;
	assign bus.reg_rd = 1'b0;
endmodule

// ===== verification/dmc_props.sv
/*
 * Assertions on the engine register port: setup order played by the host.
 * Assumes one clock domain and the register map of dmc_pkg.
 */
`timescale 1ns/10ps
module dmc_props
	import dmc_pkg::*;
(
	// clock and reset
	input wire logic           clk,
	input wire logic           rst_n,
	// register port
	input wire logic [5:0]     reg_addr,
	input wire logic [15:0]    reg_wdata,
	input wire logic           reg_wr,
	input wire logic           reg_rd,
	input wire logic [15:0]    reg_rdata,
	input wire logic [NCH-1:0] irq
);
	logic gwr;
	logic lwr;
	logic cwr;

	assign gwr = reg_wr && reg_addr == A_GCTL;
	assign lwr = reg_wr && reg_addr == A_LOWER;
	// channel control write, any channel
	assign cwr = reg_wr && reg_addr >= A_CH0 && reg_addr[2:0] == O_CTL;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_ON_FIRST: assert property (gwr |-> reg_wdata[B_ON])
		else $error("engine write without engine_on");
	AST_GCTL_UNUSED: assert property (gwr |-> reg_wdata[14:1] == 14'h0000)
		else $error("unused global bits written nonzero");
	AST_LIMITS_NEXT: assert property (gwr |=>
		reg_wr && reg_addr == A_UPPER ##1 lwr)
		else $error("limits not written after global");
	AST_DISABLE_FIRST: assert property (lwr |=> cwr && !reg_wdata[B_EN])
		else $error("channel not disabled before setup");
	AST_SETUP_ORDER: assert property (lwr ##1 cwr |=>
		reg_wr && reg_addr[2:0] == O_SRC ##1
		reg_wr && reg_addr[2:0] == O_DST ##1
		reg_wr && reg_addr[2:0] == O_CNT ##1
		cwr && !reg_wdata[B_EN] ##1 cwr && reg_wdata[B_EN])
		else $error("setup writes out of order");
	AST_ENABLE_ONLY: assert property (cwr && reg_wdata[B_EN] |->
		$past(cwr) && reg_wdata == ($past(reg_wdata) | 16'h0001))
		else $error("enable write changes other fields");
	AST_TRIG_LAST: assert property (cwr && reg_wdata[B_EN] |=>
		reg_wr && reg_addr[2:0] == O_INT ##1 !reg_wr && !reg_rd)
		else $error("trigger select not last");
	AST_RSVD_ZERO: assert property (cwr |-> reg_wdata[15:11] == 5'h00)
		else $error("reserved control bits written");
	AST_SAME_CHANNEL: assert property (reg_wr && reg_addr >= A_CH0 &&
		reg_addr[2:0] == O_CNT |-> $past(reg_addr, 2) == reg_addr - 6'h02)
		else $error("pointer and count of different channels");

	cover property (irq != '0);
endmodule

// ===== verification/testbench.sv
/*
 * Bench: host and engine joined by dmc_if, data space modelled here.
 * Assumes the dmc_pkg map and one 25 MHz clock.
 */
`timescale 1ns/10ps
module testbench;
	import dmc_pkg::*;
	typedef struct packed {
		logic        wr;
		logic        care;
		logic [15:0] addr;
		logic [15:0] data;
		logic [1:0]  be;
	} dmc_note_t;
	logic           clk;
	logic           rst_n;
	logic [2:0]     usr_addr;
	logic [15:0]    usr_wdata;
	logic           usr_wr;
	logic           usr_rd;
	logic [15:0]    usr_rdata;
	logic [15:0]    mem_addr;
	logic [15:0]    mem_wdata;
	logic [15:0]    mem_rdata;
	logic [1:0]     mem_be;
	logic           mem_rd;
	logic           mem_wr;
	logic [NCH-1:0] trig;
	logic [NCH-1:0] gate;
	logic [15:0]    key;
	logic [15:0]    sb;
	logic [15:0]    db;
	logic [15:0]    r;
	dmc_note_t      notes[$];
	dmc_note_t      n;
	int             fail_count;
	int             n_tests;

	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	dmc_if bus_if (.clk(clk), .rst_n(rst_n));
	dmc_host i_dmc_host (.clk(clk), .rst_n(rst_n), .usr_addr(usr_addr),
		.usr_wdata(usr_wdata), .usr_wr(usr_wr), .usr_rd(usr_rd),
		.usr_rdata(usr_rdata), .bus(bus_if));
	dmc_device i_dmc_device (.clk(clk), .rst_n(rst_n), .bus(bus_if),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
		.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata),
		.trig(trig), .module_power_gate(gate));
	dmc_props i_dmc_props (.clk(clk), .rst_n(rst_n),
		.reg_addr(bus_if.reg_addr), .reg_wdata(bus_if.reg_wdata),
		.reg_wr(bus_if.reg_wr), .reg_rd(bus_if.reg_rd),
		.reg_rdata(bus_if.reg_rdata), .irq(bus_if.irq));

	// data space: answer one cycle on, garbage otherwise
	always @(posedge clk) begin
		if (mem_rd)
			mem_rdata <= mem_addr ^ key;
		else
			mem_rdata <= ~mem_rdata;
	end

	task automatic check(input string nm, input logic [15:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	always @(posedge clk) begin
		if (rst_n && (mem_rd || mem_wr)) begin
			if (notes.size() == 0) begin
				check("pending notes", 16'h0000, 16'h0001);
			end else begin
				n = notes.pop_front();
				check("strobe", {15'h0, mem_wr}, {15'h0, n.wr});
				check("address", mem_addr, n.addr);
				if (n.care)
					check("lanes", {14'h0, mem_be}, {14'h0, n.be});
				if (n.care && n.wr)
					check("wdata", mem_wdata, n.data);
			end
		end
	end

	task automatic uw(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		usr_addr <= a;
		usr_wdata <= d;
		usr_wr <= 1'h1;
		@(posedge clk);
		usr_wr <= 1'h0;
	endtask

	task automatic ur(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk);
		usr_addr <= a;
		usr_rd <= 1'h1;
		@(posedge clk);
		usr_rd <= 1'h0;
		#1;
		d = usr_rdata;
	endtask

	// one read then one write, plus the dummy write back to source when nw is set
	task automatic item(input logic [15:0] s, d, input logic by, nw);
		logic [15:0] v;
		logic [7:0]  b;
		v = s ^ key;
		b = s[0] ? v[15:8] : v[7:0];
		notes.push_back('{1'h0, 1'h1, s, 16'h0000,
			by ? (s[0] ? 2'h2 : 2'h1) : 2'h3});
		notes.push_back('{1'h1, 1'h1, d, by ? {b, b} : v,
			by ? (d[0] ? 2'h2 : 2'h1) : 2'h3});
		if (nw)
			notes.push_back('{1'h1, 1'h0, s, 16'h0000, 2'h0});
	endtask

	// limits fixed so that the upper half of RAM stays forbidden
	task automatic setup(input logic [15:0] s, d, c, ctl, input logic ch, rr);
		uw(U_SRC, s);
		uw(U_DST, d);
		uw(U_CNT, c);
		uw(U_CTL, ctl);
		uw(U_UP, 16'h1FFF);
		uw(U_LOW, 16'h1000);
		uw(U_CMD, {1'h0, 7'h05, 3'h0, ch, 2'h0, rr, 1'h1});
		r = 16'h8000;
		for (int i = 0; i < 40 && r[C_BUSY] !== 1'h0; i++)
			ur(U_CMD, r);
		check("busy", {15'h0, r[C_BUSY]}, 16'h0000);
	endtask

	task automatic drain(input int k);
		for (int i = 0; i < 80 && notes.size() != 0; i++)
			@(posedge clk);
		repeat (10) @(posedge clk);
		check("notes left", 16'(notes.size()), 16'h0000);
		$display("test %0d done", k);
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		$display("wrong value watchdog: expected done seen hang");
		close_out();
	end

	initial begin
		rst_n = 1'h0;
		usr_addr = 3'h0;
		usr_wdata = 16'h0000;
		usr_wr = 1'h0;
		usr_rd = 1'h0;
		mem_rdata = 16'h0000;
		trig = 2'h0;
		gate = 2'h0;
		void'($urandom(26));
		key = $urandom;
		sb = {5'h02, key[10:1], 1'h0};
		db = sb ^ 16'h0800;
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		// word one-shot by software request, both pointers step up
		item(sb, db, 1'h0, 1'h0);
		setup(sb, db, 16'h0001, 16'h0150, 1'h0, 1'h0);
		drain(1);
		ur(U_CMD, r);
		check("order status", r, 16'h0001);
		// continuous, source up, destination down, count of three
		for (int i = 0; i < 3; i++)
			item(sb + 16'(2 * i), db - 16'(2 * i), 1'h0, 1'h0);
		setup(sb, db, 16'h0003, 16'h0168, 1'h0, 1'h1);
		drain(2);
		// byte from odd source, going down, with dummy write
		item(sb | 16'h0001, db, 1'h1, 1'h1);
		setup(sb | 16'h0001, db, 16'h0001, 16'h0582, 1'h0, key[0]);
		drain(3);
		// repeated modes, indirect destination as base
		for (int m = 1; m < 4; m += 2) begin
			for (int i = 0; i < (m == 3 ? 2 : 1); i++)
				item(sb, db, 1'h0, 1'h0);
			setup(sb, db, 16'h0002, 16'h0130 | 16'(m << 2), 1'h0, 1'h0);
			drain(3 + m);
		end
		// destination above upper limit: read only, then flag
		notes.push_back('{1'h0, 1'h1, sb, 16'h0000, 2'h3});
		setup(sb, 16'h2000, 16'h0001, 16'h0150, 1'h1, 1'h0);
		drain(8);
		ur(U_CMD, r);
		check("limit irq", {15'h0, r[1]}, 16'h0001);
		// gated channel takes no control write, so it never starts
		@(posedge clk);
		gate <= 2'h1;
		setup(sb, db, 16'h0001, 16'h0150, 1'h0, 1'h0);
		drain(9);
		@(posedge clk);
		gate <= 2'h0;
		// hardware trigger on an enabled channel
		setup(sb, db, 16'h0001, 16'h0050, 1'h0, 1'h0);
		item(sb, db, 1'h0, 1'h0);
		@(posedge clk);
		trig <= 2'h1;
		@(posedge clk);
		trig <= 2'h0;
		drain(10);
		ur(U_CMD, r);
		check("done irq", {15'h0, r[0]}, 16'h0001);
		// reload: second trigger starts from the same pointers
		setup(sb, db, 16'h0001, 16'h0254, 1'h0, 1'h0);
		for (int i = 0; i < 2; i++) begin
			item(sb, db, 1'h0, 1'h0);
			@(posedge clk);
			trig <= 2'h1;
			@(posedge clk);
			trig <= 2'h0;
			drain(11 + i);
		end
		// both triggered at once: channel 0 first
		setup(db, sb, 16'h0001, 16'h0050, 1'h1, 1'h0);
		setup(sb, db, 16'h0001, 16'h0050, 1'h0, 1'h0);
		item(sb, db, 1'h0, 1'h0);
		item(db, sb, 1'h0, 1'h0);
		@(posedge clk);
		trig <= 2'h3;
		@(posedge clk);
		trig <= 2'h0;
		drain(13);
		close_out();
	end
endmodule
